//--- design/gopm_output_pin_mux.sv
// Output pin function multiplexer with its configuration and level registers.
`timescale 1ns/1ps
`default_nettype none
module gopm_output_pin_mux #(
  parameter int NUM_PINS = 4
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          regPage,
  input  wire logic [7:0]          regAddr,
  input  wire logic                regWrite,
  input  wire logic [7:0]          regWdata,
  output logic      [7:0]          regRdata,
  input  wire logic                irqLine,
  input  wire logic                secondarySerialOut,
  input  wire logic                secondarySerialOe,
  input  wire logic                pdmClockOut,
  output logic                     bidirPin1Level,
  output logic      [NUM_PINS-1:0] pinOut,
  output logic      [NUM_PINS-1:0] pinOe,
  output logic      [NUM_PINS-1:0] pinPullUp,
  output logic      [NUM_PINS-1:0] pinPullDown
);
  // ==========================================================================
  // Register file.
  logic [7:0] pinCfg [NUM_PINS];
  logic [7:0] levels;

  // ==========================================================================
  // Page and level register decode.
  // A write off page zero reaches no register at all.
  wire logic       pageHit     = (regPage == gopm_pkg::REG_PAGE);
  wire logic       levelsHit   = (regAddr == gopm_pkg::OUT_LEVELS_ADDR);
  wire logic       levelsWe    = regWrite && pageHit && levelsHit;
  wire logic [7:0] levelsWdata = regWdata & gopm_pkg::LEVELS_MASK;

  // ==========================================================================
  // Level register.
  // The reserved low bits are never stored, so they always read as zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      levels <= gopm_pkg::LEVELS_RESET;
    end else if (levelsWe) begin
      levels <= levelsWdata;
    end
  end

  assign bidirPin1Level = levels[gopm_pkg::BIDIR_LEVEL_BIT];

  // ==========================================================================
  // Per-pin address decode; pin n answers at the first pin's address plus n.
  // Every pin address comes from one base, so the map stays dense.
  wire logic [NUM_PINS-1:0] cfgHit;
  wire logic [NUM_PINS-1:0] cfgWe;
  wire logic [7:0]          cfgWdata = regWdata & gopm_pkg::CFG_WRITE_MASK;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gDecode
    wire logic [7:0] myAddr = gopm_pkg::OUT1_CFG_ADDR + 8'(i);

    assign cfgHit[i] = (regAddr == myAddr);
    assign cfgWe[i]  = regWrite && pageHit && cfgHit[i];
  end

  // ==========================================================================
  // Per-pin configuration registers.
  // The reserved bit is never stored, so it cannot read back as one.
  // Reset is asynchronous, so every pin is released at once.
  for (genvar i = 0; i < NUM_PINS; i++) begin : gCfg
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        pinCfg[i] <= gopm_pkg::CFG_RESET;
      end else if (cfgWe[i]) begin
        pinCfg[i] <= cfgWdata;
      end
    end
  end

  // ==========================================================================
  // Function decode.
  // Reserved codes match no source, so such a pin stays disabled.
  // The decode is one-hot, so at most one source is ever selected.
  wire logic [NUM_PINS-1:0] fnGpo;
  wire logic [NUM_PINS-1:0] fnIrq;
  wire logic [NUM_PINS-1:0] fnSer;
  wire logic [NUM_PINS-1:0] fnPdm;
  wire logic [NUM_PINS-1:0] enabled;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gFunc
    wire logic [3:0] func = pinCfg[i][gopm_pkg::FUNC_MSB:gopm_pkg::FUNC_LSB];

    assign fnGpo[i]   = (func == gopm_pkg::GOPM_FN_GPO);
    assign fnIrq[i]   = (func == gopm_pkg::GOPM_FN_IRQ);
    assign fnSer[i]   = (func == gopm_pkg::GOPM_FN_SER2);
    assign fnPdm[i]   = (func == gopm_pkg::GOPM_FN_PDM);
    assign enabled[i] = fnGpo[i] | fnIrq[i] | fnSer[i] | fnPdm[i];
  end

  // ==========================================================================
  // Source selection.
  // Level bits count downwards from the first pin's bit.
  // A disabled pin selects nothing and so presents a steady low.
  wire logic [NUM_PINS-1:0] levelBit;
  wire logic [NUM_PINS-1:0] srcLevel;
  wire logic [NUM_PINS-1:0] srcIrq;
  wire logic [NUM_PINS-1:0] srcSer;
  wire logic [NUM_PINS-1:0] srcPdm;
  wire logic [NUM_PINS-1:0] srcVal;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gSrc
    assign levelBit[i] = levels[gopm_pkg::OUT1_LEVEL_BIT - i];
    assign srcLevel[i] = fnGpo[i] & levelBit[i];
    assign srcIrq[i]   = fnIrq[i] & irqLine;
    assign srcSer[i]   = fnSer[i] & secondarySerialOut;
    assign srcPdm[i]   = fnPdm[i] & pdmClockOut;
    assign srcVal[i]   = srcLevel[i] | srcIrq[i] | srcSer[i] | srcPdm[i];
  end

  // ==========================================================================
  // Drive decode.
  // Each mode says whether a low and a high are driven hard or weakly.
  // Codes above the last mode drive nothing, the same as high impedance.
  wire logic [NUM_PINS-1:0] drvPush;
  wire logic [NUM_PINS-1:0] drvLoWeakHi;
  wire logic [NUM_PINS-1:0] drvLoHiz;
  wire logic [NUM_PINS-1:0] drvWeakLoHi;
  wire logic [NUM_PINS-1:0] drvHizHi;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gDrvDecode
    wire logic [2:0] drv = pinCfg[i][gopm_pkg::DRV_MSB:gopm_pkg::DRV_LSB];

    assign drvPush[i]     = (drv == gopm_pkg::GOPM_DRV_PUSHPULL);
    assign drvLoWeakHi[i] = (drv == gopm_pkg::GOPM_DRV_LO_WEAKHI);
    assign drvLoHiz[i]    = (drv == gopm_pkg::GOPM_DRV_LO_HIZ);
    assign drvWeakLoHi[i] = (drv == gopm_pkg::GOPM_DRV_WEAKLO_HI);
    assign drvHizHi[i]    = (drv == gopm_pkg::GOPM_DRV_HIZ_HI);
  end

  // ==========================================================================
  // Drive strength per level.
  // A weak level is left to the pad's pull and never driven hard.
  wire logic [NUM_PINS-1:0] hardLow;
  wire logic [NUM_PINS-1:0] hardHigh;
  wire logic [NUM_PINS-1:0] weakLow;
  wire logic [NUM_PINS-1:0] weakHigh;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gStrength
    assign hardLow[i]  = drvPush[i] | drvLoWeakHi[i] | drvLoHiz[i];
    assign hardHigh[i] = drvPush[i] | drvWeakLoHi[i] | drvHizHi[i];
    assign weakLow[i]  = drvWeakLoHi[i];
    assign weakHigh[i] = drvLoWeakHi[i];
  end

  // ==========================================================================
  // Serial bypass.
  // The serial port switches its own enable, so the drive field is unused.
  wire logic [NUM_PINS-1:0] serOe;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gSer
    assign serOe[i] = fnSer[i] & secondarySerialOe;
  end

  // ==========================================================================
  // Drive stage.
  // Pulls act only while the pin is released, so they never fight a driver.
  // The serial function bypasses the stage entirely.
  wire logic [NUM_PINS-1:0] useStage;
  wire logic [NUM_PINS-1:0] stageOe;
  wire logic [NUM_PINS-1:0] stageUp;
  wire logic [NUM_PINS-1:0] stageDown;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gStage
    assign useStage[i]  = enabled[i] & !fnSer[i];
    assign stageOe[i]   = srcVal[i] ? hardHigh[i] : hardLow[i];
    assign stageUp[i]   = weakHigh[i] & srcVal[i];
    assign stageDown[i] = weakLow[i] & !srcVal[i];
  end

  // ==========================================================================
  // Pin outputs.
  // The level is shown even while the pin is released.
  for (genvar i = 0; i < NUM_PINS; i++) begin : gOut
    assign pinOut[i]      = srcVal[i];
    assign pinOe[i]       = serOe[i] | (useStage[i] & stageOe[i]);
    assign pinPullUp[i]   = useStage[i] & stageUp[i];
    assign pinPullDown[i] = useStage[i] & stageDown[i];
  end

  // ==========================================================================
  // Read data.
  // Off page zero, or at an unmapped address, the port reads zero.
  logic [7:0] cfgRead [NUM_PINS];
  logic [7:0] cfgMerged;

  for (genvar i = 0; i < NUM_PINS; i++) begin : gRead
    assign cfgRead[i] = cfgHit[i] ? pinCfg[i] : 8'h00;
  end

  always_comb begin
    cfgMerged = 8'h00;
    for (int k = 0; k < NUM_PINS; k++) begin
      cfgMerged = cfgMerged | cfgRead[k];
    end
  end

  assign regRdata = !pageHit  ? 8'h00
                  : levelsHit ? levels
                  : cfgMerged;
endmodule // gopm_output_pin_mux
`default_nettype wire

//--- design/gopm_pkg.sv
// Package with register map, field layout and encodings for the output pin mux.
package gopm_pkg;
  // ==========================================================================
  // Register offsets on page zero.
  localparam logic [7:0] OUT1_CFG_ADDR   = 8'h22;
  localparam logic [7:0] OUT2_CFG_ADDR   = 8'h23;
  localparam logic [7:0] OUT3_CFG_ADDR   = 8'h24;
  localparam logic [7:0] OUT4_CFG_ADDR   = 8'h25;
  localparam logic [7:0] OUT_LEVELS_ADDR = 8'h29;
  localparam logic [7:0] REG_PAGE        = 8'h00;
  // ==========================================================================
  // Reset values and field layout.
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] LEVELS_RESET    = 8'h00;
  localparam int         FUNC_MSB        = 7;
  localparam int         FUNC_LSB        = 4;
  localparam int         DRV_MSB         = 2;
  localparam int         DRV_LSB         = 0;
  localparam logic [7:0] CFG_WRITE_MASK  = 8'hF7;
  localparam logic [7:0] LEVELS_MASK     = 8'hF8;
  localparam int         BIDIR_LEVEL_BIT = 7;
  localparam int         OUT1_LEVEL_BIT  = 6;
  // ==========================================================================
  // Function and drive encodings.
  typedef enum logic [3:0] {
    GOPM_FN_OFF  = 4'h0,
    GOPM_FN_GPO  = 4'h1,
    GOPM_FN_IRQ  = 4'h2,
    GOPM_FN_SER2 = 4'h3,
    GOPM_FN_PDM  = 4'h4
  } gopm_func_t;
  typedef enum logic [2:0] {
    GOPM_DRV_HIZ      = 3'h0,
    GOPM_DRV_PUSHPULL = 3'h1,
    GOPM_DRV_LO_WEAKHI = 3'h2,
    GOPM_DRV_LO_HIZ   = 3'h3,
    GOPM_DRV_WEAKLO_HI = 3'h4,
    GOPM_DRV_HIZ_HI   = 3'h5
  } gopm_drive_t;
endpackage

//--- dv/gopm_board_model.sv
// Board model giving the level seen on each pin.
`timescale 1ns/1ps
`default_nettype none
module gopm_board_model (
  input  wire logic [3:0] pinOut, pinOe, pinPullUp, pinPullDown,
  output logic      [3:0] pinWire
);
  // A floating pin shows the inverse level so it never passes for a match.
  assign pinWire = pinOe & pinOut | ~pinOe & (pinPullUp | ~pinPullDown & ~pinOut);
endmodule // gopm_board_model
`default_nettype wire

//--- dv/gopm_pin_mux_chk.sv
// Checker for output pin mux registers and pins.
`timescale 1ns/1ps
`default_nettype none
module gopm_pin_mux_chk #(parameter int NUM_PINS = 4) (
  input wire logic                core_clk, rst_n, regWrite,
  input wire logic [7:0]          regPage, regAddr, regWdata, regRdata,
  input wire logic [NUM_PINS-1:0] pinOut, pinOe, pinPullUp, pinPullDown
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic wr0  = regWrite && regPage == 8'h00;
  wire logic cfgA = regAddr inside {[8'h22:8'h25]};
  cfg_write_a: assert property (wr0 && cfgA |=> $changed(regAddr)
    || regRdata == ($past(regWdata) & 8'hF7)) else $error("cfg read wrong");
  level_write_a: assert property (wr0 && regAddr == 8'h29 |=> $changed(regAddr)
    || regRdata == ($past(regWdata) & 8'hF8)) else $error("level read wrong");
  reserved_bit_a: assert property (cfgA |-> !regRdata[3]) else $error("bit 3 set");
  unmapped_zero_a: assert property (regPage != 8'h00 || !cfgA && regAddr != 8'h29
    |-> regRdata == 8'h00) else $error("unmapped read");
  pull_excl_a: assert property (((pinPullUp | pinPullDown) & pinOe) == 0
    && (pinPullUp & pinPullDown) == 0) else $error("pull clash");
  pull_level_a: assert property ((pinPullUp & ~pinOut) == 0
    && (pinPullDown & pinOut) == 0) else $error("pull level");
  off_pin_a: assert property (wr0 && regAddr == 8'h25 && regWdata[7:4] == 4'h0
    |=> {pinOe[3], pinOut[3], pinPullUp[3], pinPullDown[3]} == 4'h0) else $error("off pin");
  reset_value_a: assert property ($rose(rst_n) |-> pinOe == 0 && regRdata == 8'h00)
    else $error("reset state");
  cover property (wr0 && regAddr == 8'h29);
  cover property (|pinPullUp);
  cover property (|pinPullDown);
endmodule // gopm_pin_mux_chk
`default_nettype wire

//--- dv/gopm_tb.sv
// Testbench for the output pin mux.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       core_clk = '0, rst_n = '0, regWrite = '0, irqLine = '0, secondarySerialOut = '0;
  logic       secondarySerialOe = '0, pdmClockOut = '0, bidirPin1Level;
  logic [7:0] regPage = '0, regAddr = '0, regWdata = '0, regRdata;
  logic [3:0] pinOut, pinOe, pinPullUp, pinPullDown, pinWire;
  int         fails = 0, n_compared = 0;
  logic [19:0] rows [17] = '{20'h10108, 20'h1110C, 20'h11004, 20'h1210A, 20'h12004, 20'h13108,
    20'h13004, 20'h1410C, 20'h14001, 20'h1510C, 20'h15000, 20'h2108C, 20'h3106C, 20'h32048,
    20'h30024, 20'h4101C, 20'h01100};
  always #2 core_clk = ~core_clk;
  gopm_output_pin_mux uut (.core_clk, .rst_n, .regPage, .regAddr, .regWrite, .regWdata,
    .regRdata, .irqLine, .secondarySerialOut, .secondarySerialOe, .pdmClockOut,
    .bidirPin1Level, .pinOut, .pinOe, .pinPullUp, .pinPullDown);
  gopm_board_model board (.pinOut, .pinOe, .pinPullUp, .pinPullDown, .pinWire);
  task chk(input string n, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] p, a, d);
    @(posedge core_clk) #1 {regPage, regAddr, regWdata, regWrite} = {p, a, d, 1'b1};
    @(posedge core_clk) #1 regWrite = 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge core_clk) #1 {regPage, regAddr} = {8'h00, a};
    #1 chk("reg", regRdata, e);
  endtask
  task results;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #4000 fails++;
    results;
  end
  initial begin
    int p;
    logic [19:0] r;
    logic [3:0] s;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 5; i++) rd(i < 4 ? 8'h22 + i[7:0] : 8'h29, 8'h00);
    chk("oe", {4'h0, pinOe}, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      p = i % 4;
      r = rows[i];
      @(posedge core_clk) #1 {irqLine, secondarySerialOut, secondarySerialOe, pdmClockOut} = r[7:4];
      wr(8'h00, 8'h29, {7'h00, r[8]} << (6 - p));
      wr(8'h00, 8'h22 + p[7:0], r[19:12]);
      #1 s = {pinOut[p], pinOe[p], pinPullUp[p], pinPullDown[p]};
      chk("pin", {4'h0, s}, {4'h0, r[3:0]});
      rd(8'h22 + p[7:0], r[19:12]);
      if (|r[2:0]) chk("wire", {7'h00, pinWire[p]}, {7'h00, r[3]});
    end
    $display("table test done");
    wr(8'h00, 8'h23, 8'h1D);
    rd(8'h23, 8'h15);
    wr(8'h00, 8'h29, 8'hFF);
    rd(8'h29, 8'hF8);
    chk("bidir", {7'h00, bidirPin1Level}, 8'h01);
    wr(8'h01, 8'h23, 8'h00);
    wr(8'h00, 8'h26, 8'hFF);
    rd(8'h23, 8'h15);
    rd(8'h26, 8'h00);
    wr(8'h00, 8'h25, 8'h01);
    #1 chk("off", {7'h00, pinOe[3]}, 8'h00);
    $display("edge test done");
    @(posedge core_clk) #1 rst_n = 1'b0;
    rd(8'h29, 8'h00);
    @(posedge core_clk) #1 rst_n = 1'b1;
    rd(8'h23, 8'h00);
    chk("oe2", {4'h0, pinOe}, 8'h00);
    $display("second reset done");
    results;
  end
endmodule // testbench
bind gopm_output_pin_mux gopm_pin_mux_chk #(.NUM_PINS(NUM_PINS)) watch (.core_clk, .rst_n,
  .regWrite, .regPage, .regAddr, .regWdata, .regRdata, .pinOut, .pinOe, .pinPullUp, .pinPullDown);
`default_nettype wire
